// ===== verilog/rca_top.sv
// command interpreter, access levels, alarm, close, remote bits, log
// Behaviour
// - level 2 entry attempt pulses alarm one second unless alarm holds
// - three consecutive wrong level 1 passwords pulse alarm one second
// - breaker level entry attempt pulses alarm unless alarm holds
// - breaker level allows level 1 plus breaker commands, own prompt
// - confirmed close asserts element only if no trip, breaker open
// - close element holds 30 line cycles or until breaker closes
// - two yes answers needed for close; a no aborts
// - missing breaker jumper refuses close with jumper abort report
// - channel failure log: start, end, duration, type, 255 entries
// - control command only at level 2, bit index 1 to 16
// - remote bit set, clear, pulse t seconds, default one second
// - subcommand index must match control index to act
// - copy group m to n, 1 to 6, after confirmation
// - copy marks stored events of destination group as changed
// - setting change in active group pulses alarm
// - twelve events, 1 newest, 12 oldest, none means newest
// - quarter cycle default format, four sixteenth cycle selectors
// - empty event slot answers invalid event
// - power loss clears events; summaries kept in nonvolatile store
// - group variable 1 to 6 rules when no select input asserted
// - group change pulses alarm, sends message, keeps events
// - level 1 group only reports; protection paused on switch
// - power up in level 0, only level 1 entry accepted
`default_nettype none
module rca_top
	import rca_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trip_asserted,
	input wire logic breaker_open,
	input wire logic breaker_enable_jumper,
	input wire logic alarm_condition,
	input wire logic channel_fail,
	input wire logic [2:0] channel_fail_type,
	input wire logic event_trigger,
	input wire logic [2:0] group_select_input,
	output logic alarm_out,
	output logic close_command_element,
	output logic [15:0] remote_control_bit,
	output logic [2:0] active_group,
	output logic group_msg,
	output logic protection_disable,
	output logic copy_go,
	output logic [2:0] copy_src,
	output logic [2:0] copy_dst,
	output logic summary_strobe
);
	localparam int NSYNC = 12;
	logic [NSYNC-1:0] sync1, sync2;
	logic trip_s, open_s, jmp_s, acond_s, cfail_s, etrig_s;
	logic [2:0] ctype_s, gsel_s;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= {trip_asserted, breaker_open, breaker_enable_jumper,
				alarm_condition, channel_fail, channel_fail_type,
				event_trigger, group_select_input};
			sync2 <= sync1;
		end
	assign {trip_s, open_s, jmp_s, acond_s, cfail_s, ctype_s, etrig_s,
		gsel_s} = sync2;

	// millisecond tick and timestamp
	logic [17:0] tick_cnt;
	logic tick;
	logic [15:0] ts;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tick_cnt <= '0;
			tick <= 1'b0;
			ts <= '0;
		end
		else
		begin
			tick <= (tick_cnt == 18'(TICK_CYC - 1));
			tick_cnt <= (tick_cnt == 18'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
			if (tick)
				ts <= ts + 1'b1;
		end

	// apb slave, no wait states
	logic wr_go;
	logic cmd_go;
	logic [31:0] cmd;
	logic [2:0] grp_mask;
	logic [7:0] log_idx;
	assign wr_go = psel & penable & pready & pwrite;
	assign cmd_go = wr_go & (paddr == REG_CMD);
	assign cmd = pwdata;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			grp_mask <= '0;
			log_idx <= '0;
		end
		else if (wr_go && paddr == REG_CFG)
			grp_mask <= pwdata[2:0];
		else if (wr_go && paddr == REG_LOG_IDX)
			log_idx <= pwdata[7:0];

	// command interpreter
	rca_level_t level;
	rca_result_t result;
	rca_confirm_t cstate;
	logic [1:0] wrong_cnt;
	logic [4:0] ctl_idx;
	logic [2:0] group_var, pend_a, pend_b;
	logic alarm_req, close_go, sub_go, mark_go, log_clr;
	logic [1:0] sub_kind;
	logic [3:0] sub_bit, sub_dur;
	logic [2:0] mark_grp, ev_fmt;
	logic [3:0] ev_sel;
	logic [NUM_EVENTS-1:0] ev_valid, ev_chg;
	rca_op_t op;
	logic [3:0] a, b, c;
	logic [3:0] ev_req;
	assign op = rca_op_t'(cmd[CMD_OP_LSB +: 4]);
	assign a = cmd[CMD_A_LSB +: 4];
	assign b = cmd[CMD_B_LSB +: 4];
	assign c = cmd[CMD_C_LSB +: 4];
	assign ev_req = (a == 4'h0) ? 4'h1 : a;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			level <= LVL0;
			result <= RES_OK;
			cstate <= CF_IDLE;
			wrong_cnt <= '0;
			ctl_idx <= '0;
			group_var <= GROUP_VAR_RST;
			pend_a <= '0;
			pend_b <= '0;
			alarm_req <= 1'b0;
			close_go <= 1'b0;
			sub_go <= 1'b0;
			sub_kind <= '0;
			sub_bit <= '0;
			sub_dur <= '0;
			copy_go <= 1'b0;
			copy_src <= '0;
			copy_dst <= '0;
			mark_go <= 1'b0;
			mark_grp <= '0;
			log_clr <= 1'b0;
			ev_sel <= 4'h1;
			ev_fmt <= '0;
		end
		else
		begin
			alarm_req <= 1'b0;
			close_go <= 1'b0;
			sub_go <= 1'b0;
			copy_go <= 1'b0;
			mark_go <= 1'b0;
			log_clr <= 1'b0;
			if (cmd_go)
			begin
				if (op != OP_YES && op != OP_NO)
					cstate <= CF_IDLE;
				// an armed control index is good for the next command only
				if (op != OP_SUB)
					ctl_idx <= '0;
				if (level == LVL0 && op != OP_ACCESS)
					result <= RES_BAD_LEVEL;
				else
					unique case (op)
					OP_ACCESS:
						if (cmd[CMD_PW_BIT])
						begin
							level <= LVL1;
							wrong_cnt <= '0;
							result <= RES_OK;
						end
						else
						begin
							result <= RES_BAD_PW;
							if (wrong_cnt == 2'(WRONG_LIMIT - 1))
							begin
								alarm_req <= 1'b1;
								wrong_cnt <= '0;
							end
							else
								wrong_cnt <= wrong_cnt + 1'b1;
						end
					OP_BREAKER, OP_TOP:
					begin
						alarm_req <= !acond_s;
						if (cmd[CMD_PW_BIT])
						begin
							level <= (op == OP_TOP) ? LVL2 : LVL_BRK;
							result <= RES_OK;
						end
						else
							result <= RES_BAD_PW;
					end
					OP_CLOSE:
						if (level < LVL_BRK)
							result <= RES_BAD_LEVEL;
						else if (!jmp_s)
							result <= RES_NO_JUMPER;
						else
						begin
							cstate <= CF_CLOSE1;
							result <= RES_ASK;
						end
					OP_YES:
						unique case (cstate)
						CF_IDLE:
							result <= RES_BAD_CMD;
						CF_CLOSE1:
						begin
							cstate <= CF_CLOSE2;
							result <= RES_ASK;
						end
						CF_CLOSE2:
						begin
							cstate <= CF_IDLE;
							if (!trip_s && open_s)
							begin
								close_go <= 1'b1;
								result <= RES_CLOSED;
							end
							else
								result <= RES_REFUSED;
						end
						CF_COPY:
						begin
							cstate <= CF_IDLE;
							copy_go <= 1'b1;
							copy_src <= pend_a;
							copy_dst <= pend_b;
							mark_go <= 1'b1;
							mark_grp <= pend_b;
							alarm_req <= (pend_b == active_group);
							result <= RES_OK;
						end
						CF_GROUP:
						begin
							cstate <= CF_IDLE;
							group_var <= pend_a;
							result <= RES_OK;
						end
						default:
						begin
							cstate <= CF_IDLE;
							result <= RES_BAD_CMD;
						end
						endcase
					OP_NO:
					begin
						result <= (cstate == CF_IDLE) ? RES_BAD_CMD
							: RES_ABORTED;
						cstate <= CF_IDLE;
					end
					OP_CONTROL:
						if (level != LVL2)
							result <= RES_BAD_LEVEL;
						else if (a == 4'h0 && b == 4'h0)
							result <= RES_BAD_ARG;
						else
						begin
							ctl_idx <= 5'(a) + 5'(b == 4'h1 ? 5'h10 : 5'h0);
							result <= RES_ASK;
						end
					OP_SUB:
						if (ctl_idx == 5'h0 || ctl_idx != 5'(a) + 5'h1
							|| c[3:2] == 2'h0)
						begin
							result <= RES_BAD_ARG;
							ctl_idx <= '0;
						end
						else
						begin
							sub_go <= 1'b1;
							sub_bit <= a;
							sub_kind <= c[1:0];
							sub_dur <= (b == 4'h0) ? 4'(RB_PULSE_DEF_S) : b;
							ctl_idx <= '0;
							result <= RES_OK;
						end
					OP_COPY:
						if (level != LVL2)
							result <= RES_BAD_LEVEL;
						else if (a == 4'h0 || a > 4'(NUM_GROUPS) || b == 4'h0
							|| b > 4'(NUM_GROUPS))
							result <= RES_BAD_ARG;
						else
						begin
							pend_a <= a[2:0];
							pend_b <= b[2:0];
							cstate <= CF_COPY;
							result <= RES_ASK;
						end
					OP_GROUP:
						if (a == 4'h0)
							result <= RES_OK;
						else if (level < LVL_BRK)
							result <= RES_BAD_LEVEL;
						else if (a > 4'(NUM_GROUPS))
							result <= RES_BAD_ARG;
						else
						begin
							pend_a <= a[2:0];
							cstate <= CF_GROUP;
							result <= RES_ASK;
						end
					OP_EVENT:
						if (ev_req > 4'(NUM_EVENTS) || b > 4'h4)
							result <= RES_BAD_ARG;
						else if (!ev_valid[ev_req - 4'h1])
							result <= RES_BAD_EVENT;
						else
						begin
							ev_sel <= ev_req;
							ev_fmt <= b[2:0];
							result <= RES_OK;
						end
					OP_SETCHG:
						if (level != LVL2)
							result <= RES_BAD_LEVEL;
						else
						begin
							alarm_req <= (a[2:0] == active_group);
							mark_go <= 1'b1;
							mark_grp <= a[2:0];
							result <= RES_OK;
						end
					OP_LOGCLR:
					begin
						log_clr <= 1'b1;
						result <= RES_OK;
					end
					default:
						result <= RES_BAD_CMD;
					endcase
			end
		end

	// active group, alarm on switch, message, protection pause
	logic [2:0] sel, next_active;
	logic [1:0] prot_tmr;
	logic grp_alarm;
	assign sel = gsel_s & grp_mask;
	assign next_active = (sel == 3'h0) ? group_var
		: (sel > 3'(NUM_GROUPS)) ? 3'(NUM_GROUPS) : sel;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			active_group <= GROUP_VAR_RST;
			group_msg <= 1'b0;
			grp_alarm <= 1'b0;
			prot_tmr <= '0;
			protection_disable <= 1'b0;
		end
		else
		begin
			active_group <= next_active;
			group_msg <= (next_active != active_group);
			grp_alarm <= (next_active != active_group);
			if (next_active != active_group)
				prot_tmr <= 2'(PROT_OFF_MS);
			else if (tick && prot_tmr != 2'h0)
				prot_tmr <= prot_tmr - 1'b1;
			protection_disable <= (prot_tmr != 2'h0);
		end

	// alarm pulse
	logic [9:0] alarm_tmr;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			alarm_tmr <= '0;
			alarm_out <= 1'b0;
		end
		else
		begin
			if (alarm_req || grp_alarm)
				alarm_tmr <= 10'(ALARM_PULSE_MS);
			else if (tick && alarm_tmr != 10'h0)
				alarm_tmr <= alarm_tmr - 1'b1;
			alarm_out <= acond_s || (alarm_tmr != 10'h0);
		end

	// close element
	logic [8:0] close_tmr;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			close_tmr <= '0;
			close_command_element <= 1'b0;
		end
		else if (close_go)
		begin
			close_tmr <= 9'(CLOSE_HOLD_MS);
			close_command_element <= 1'b1;
		end
		else if (!open_s || (tick && close_tmr == 9'h1))
		begin
			close_tmr <= '0;
			close_command_element <= 1'b0;
		end
		else if (tick && close_tmr != 9'h0)
			close_tmr <= close_tmr - 1'b1;

	// remote control bits
	genvar gi;
	generate
		for (gi = 0; gi < NUM_RBITS; gi++)
		begin : g_rb
			logic [13:0] tmr;
			logic hit;
			assign hit = sub_go && sub_bit == 4'(gi);
			always_ff @(posedge pclk or negedge presetn)
				if (!presetn)
				begin
					tmr <= '0;
					remote_control_bit[gi] <= 1'b0;
				end
				else if (hit && sub_kind == SUB_SET)
				begin
					tmr <= '0;
					remote_control_bit[gi] <= 1'b1;
				end
				else if (hit && sub_kind == SUB_CLR)
				begin
					tmr <= '0;
					remote_control_bit[gi] <= 1'b0;
				end
				else if (hit && sub_kind == SUB_PULSE)
				begin
					tmr <= 14'(sub_dur) * 14'd1000;
					remote_control_bit[gi] <= 1'b1;
				end
				else if (tick && tmr != 14'h0)
				begin
					tmr <= tmr - 1'b1;
					if (tmr == 14'h1)
						remote_control_bit[gi] <= 1'b0;
				end
		end
	endgenerate

	// event slots, slot 0 newest
	logic etrig_d;
	logic [2:0] ev_grp [NUM_EVENTS];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			etrig_d <= 1'b0;
			summary_strobe <= 1'b0;
		end
		else
		begin
			etrig_d <= etrig_s;
			summary_strobe <= etrig_s & ~etrig_d;
		end
	generate
		for (gi = 0; gi < NUM_EVENTS; gi++)
		begin : g_ev
			localparam int PREV = (gi == 0) ? 0 : gi - 1;
			always_ff @(posedge pclk or negedge presetn)
				if (!presetn)
				begin
					ev_valid[gi] <= 1'b0;
					ev_chg[gi] <= 1'b0;
					ev_grp[gi] <= '0;
				end
				else if (etrig_s && !etrig_d)
				begin
					ev_valid[gi] <= (gi == 0) ? 1'b1 : ev_valid[PREV];
					// a mark that lands with a new event is kept
					ev_chg[gi] <= (gi == 0) ? 1'b0 : ev_chg[PREV] || (mark_go
						&& ev_valid[PREV] && ev_grp[PREV] == mark_grp);
					ev_grp[gi] <= (gi == 0) ? active_group : ev_grp[PREV];
				end
				else if (mark_go && ev_valid[gi] && ev_grp[gi] == mark_grp)
					ev_chg[gi] <= 1'b1;
		end
	endgenerate

	// channel failure log
	logic [34:0] log_mem [LOG_DEPTH];
	logic [7:0] log_wp, log_cnt;
	logic [15:0] fail_start;
	logic cfail_d;
	logic [8:0] rd_sum;
	logic [7:0] rd_ptr;
	logic [34:0] log_ent;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			log_wp <= '0;
			log_cnt <= '0;
			fail_start <= '0;
			cfail_d <= 1'b0;
		end
		else
		begin
			cfail_d <= cfail_s;
			if (cfail_s && !cfail_d)
				fail_start <= ts;
			if (log_clr)
			begin
				log_wp <= '0;
				log_cnt <= '0;
			end
			else if (!cfail_s && cfail_d)
			begin
				log_wp <= (log_wp == 8'(LOG_DEPTH - 1)) ? '0 : log_wp + 1'b1;
				if (log_cnt != 8'(LOG_DEPTH))
					log_cnt <= log_cnt + 1'b1;
			end
		end
	always_ff @(posedge pclk)
		if (!cfail_s && cfail_d)
			log_mem[log_wp] <= {ctype_s, ts, fail_start};
	assign rd_sum = 9'(log_wp) + 9'(LOG_DEPTH) - 9'(log_idx);
	assign rd_ptr = (rd_sum >= 9'(LOG_DEPTH)) ? 8'(rd_sum - 9'(LOG_DEPTH))
		: rd_sum[7:0];
	assign log_ent = log_mem[rd_ptr];

	// read mux
	logic [31:0] rd_data;
	logic rd_err, log_ok;
	assign log_ok = log_idx != 8'h0 && log_idx <= log_cnt;
	always_comb
	begin
		rd_data = '0;
		rd_err = 1'b0;
		unique case (paddr)
		REG_CMD:
			rd_data = '0;
		REG_STATUS:
			rd_data = {7'h0, acond_s, alarm_out, close_command_element,
				group_var, active_group, cstate, ctl_idx, result, 2'h0, level};
		REG_RBITS:
			rd_data = {16'h0, remote_control_bit};
		REG_EVENT:
			rd_data = {11'h0, ev_chg, ev_valid[NUM_EVENTS-1:0] == '0, ev_fmt,
				ev_chg[ev_sel - 4'h1], ev_sel};
		REG_CFG:
			rd_data = {29'h0, grp_mask};
		REG_LOG_IDX:
			rd_data = {16'h0, log_cnt, log_idx};
		REG_LOG_TIME:
			rd_data = log_ok ? log_ent[31:0] : '0;
		REG_LOG_INFO:
			rd_data = log_ok ? {log_ok, 12'h0, log_ent[34:32],
				log_ent[31:16] - log_ent[15:0]} : '0;
		default:
			rd_err = 1'b1;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			if (psel && !penable)
			begin
				prdata <= pwrite ? '0 : rd_data;
				pslverr <= rd_err;
			end
		end
endmodule
`default_nettype wire

// ===== shared/rca_pkg.sv
// constants and types for the relay command and access block
`default_nettype none
package rca_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int ALARM_PULSE_MS = 1000;
	localparam int LINE_HZ = 60;
	localparam int CLOSE_HOLD_CYC = 30;
	localparam int CLOSE_HOLD_MS = CLOSE_HOLD_CYC * 1000 / LINE_HZ;
	localparam int RB_PULSE_DEF_S = 1;
	localparam int PROT_OFF_MS = 2;
	localparam int NUM_EVENTS = 12;
	localparam int NUM_GROUPS = 6;
	localparam int NUM_RBITS = 16;
	localparam int LOG_DEPTH = 255;
	localparam int WRONG_LIMIT = 3;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RBITS = 8'h08;
	localparam logic [7:0] REG_EVENT = 8'h0c;
	localparam logic [7:0] REG_CFG = 8'h10;
	localparam logic [7:0] REG_LOG_IDX = 8'h14;
	localparam logic [7:0] REG_LOG_TIME = 8'h18;
	localparam logic [7:0] REG_LOG_INFO = 8'h1c;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_A_LSB = 4;
	localparam int CMD_B_LSB = 8;
	localparam int CMD_C_LSB = 12;
	localparam int CMD_PW_BIT = 16;
	localparam logic [2:0] GROUP_VAR_RST = 3'h1;
	localparam logic [1:0] SUB_SET = 2'h1;
	localparam logic [1:0] SUB_CLR = 2'h2;
	localparam logic [1:0] SUB_PULSE = 2'h3;
	typedef enum logic [3:0] {
		OP_ACCESS = 4'h1,
		OP_BREAKER = 4'h2,
		OP_TOP = 4'h3,
		OP_CLOSE = 4'h4,
		OP_YES = 4'h5,
		OP_NO = 4'h6,
		OP_CONTROL = 4'h7,
		OP_SUB = 4'h8,
		OP_COPY = 4'h9,
		OP_GROUP = 4'ha,
		OP_EVENT = 4'hb,
		OP_SETCHG = 4'hc,
		OP_LOGCLR = 4'hd
	} rca_op_t;
	typedef enum logic [1:0] {
		LVL0 = 2'h0,
		LVL1 = 2'h1,
		LVL_BRK = 2'h2,
		LVL2 = 2'h3
	} rca_level_t;
	typedef enum logic [3:0] {
		RES_OK = 4'h0,
		RES_BAD_CMD = 4'h1,
		RES_BAD_LEVEL = 4'h2,
		RES_BAD_PW = 4'h3,
		RES_ASK = 4'h4,
		RES_ABORTED = 4'h5,
		RES_NO_JUMPER = 4'h6,
		RES_REFUSED = 4'h7,
		RES_CLOSED = 4'h8,
		RES_BAD_EVENT = 4'h9,
		RES_BAD_ARG = 4'ha
	} rca_result_t;
	typedef enum logic [2:0] {
		CF_IDLE = 3'h0,
		CF_CLOSE1 = 3'h1,
		CF_CLOSE2 = 3'h2,
		CF_COPY = 3'h3,
		CF_GROUP = 3'h4
	} rca_confirm_t;
endpackage
`default_nettype wire

// ===== sim/rca_top_sva.sv
// assertion checker for the relay command block
`default_nettype none
module rca_top_chk
	import rca_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic trip_asserted,
	input wire logic breaker_open,
	input wire logic alarm_condition,
	input wire logic alarm_out,
	input wire logic close_command_element,
	input wire logic [2:0] active_group,
	input wire logic group_msg,
	input wire logic protection_disable,
	input wire logic copy_go
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CC_MAX = CLOSE_HOLD_MS * TICK_CYC + TICK_CYC + 4;
	localparam int AL_MAX = ALARM_PULSE_MS * TICK_CYC + TICK_CYC + 4;
	logic [3:0] trip_cnt;
	logic [3:0] shut_cnt;
	int cc_cnt;
	int al_cnt;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// run lengths of trip, closed breaker, close element and alarm pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trip_cnt <= 4'h0;
			shut_cnt <= 4'h0;
			cc_cnt <= 0;
			al_cnt <= 0;
		end
		else
		begin
			trip_cnt <= !trip_asserted ? 4'h0 :
				(trip_cnt == 4'hf ? trip_cnt : trip_cnt + 4'h1);
			shut_cnt <= breaker_open ? 4'h0 :
				(shut_cnt == 4'hf ? shut_cnt : shut_cnt + 4'h1);
			cc_cnt <= close_command_element ? cc_cnt + 1 : 0;
			al_cnt <= (alarm_out && !alarm_condition) ? al_cnt + 1 : 0;
		end
	end
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("no ready in the access cycle");
	AST_CLOSE_COND: assert property (
		$rose(close_command_element) |-> trip_cnt < 4'h6 && shut_cnt < 4'h6)
		else $error("close element rose with trip or breaker closed");
	AST_CLOSE_LEN: assert property (cc_cnt <= CC_MAX)
		else $error("close element held too long");
	AST_CLOSE_DROP: assert property (
		close_command_element && shut_cnt > 4'h4
		|-> ##[0:2] !close_command_element)
		else $error("close element stayed after breaker closed");
	AST_ALARM_STAND: assert property (alarm_condition [*5] |-> alarm_out)
		else $error("standing alarm not on output");
	AST_ALARM_LEN: assert property (al_cnt <= AL_MAX)
		else $error("alarm pulse too long");
	AST_GROUP_RANGE: assert property (
		active_group >= 3'h1 && active_group <= 3'h6)
		else $error("active group out of range");
	AST_GROUP_MSG: assert property ($changed(active_group) |->
		(group_msg || $past(group_msg) || $past(group_msg, 2))
		or (##[1:2] group_msg))
		else $error("group change without message");
	AST_MSG_ALARM: assert property (group_msg |-> ##[0:4] alarm_out)
		else $error("group change without alarm pulse");
	AST_PROT_OFF: assert property (
		group_msg |-> ##[0:4] protection_disable)
		else $error("protection not paused on group switch");
	AST_COPY_ONE: assert property (copy_go |=> !copy_go)
		else $error("copy strobe longer than one cycle");
endmodule
bind rca_top rca_top_chk #(.TICK_CYC(TICK_CYC)) i_chk (
	.pclk,
	.presetn,
	.psel,
	.penable,
	.pready,
	.trip_asserted,
	.breaker_open,
	.alarm_condition,
	.alarm_out,
	.close_command_element,
	.active_group,
	.group_msg,
	.protection_disable,
	.copy_go
);
`default_nettype wire

// ===== sim/rca_breaker_model.sv
// breaker mechanism answering the close element
`default_nettype none
module rca_breaker_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic close_command_element,
	input wire logic fast,
	output logic breaker_open
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt;
	// slow breaker never closes; fast one closes 20 cycles in
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 5'h0;
			breaker_open <= 1'b1;
		end
		else if (close_command_element && fast)
		begin
			cnt <= cnt + 5'h1;
			if (cnt == 5'h13)
				breaker_open <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// testbench for the relay command block
`default_nettype none
module tb
	import rca_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	localparam int AL = ALARM_PULSE_MS * TK;
	localparam int CC = CLOSE_HOLD_MS * TK;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic trip_asserted = 1'b0;
	logic breaker_enable_jumper = 1'b0;
	logic alarm_condition = 1'b0;
	logic channel_fail = 1'b0;
	logic [2:0] channel_fail_type = 3'h0;
	logic event_trigger = 1'b0;
	logic [2:0] group_select_input = 3'h0;
	logic fast = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic breaker_open;
	logic alarm_out;
	logic close_command_element;
	logic [15:0] remote_control_bit;
	logic [2:0] active_group;
	logic group_msg;
	logic protection_disable;
	logic copy_go;
	logic [2:0] copy_src;
	logic [2:0] copy_dst;
	logic summary_strobe;
	logic [31:0] rdat;
	logic rerr;
	int num_errors = 0;
	int check_count = 0;
	int n;
	int num_sum = 0;

	always #2 pclk = ~pclk;

	// count summary pushes, each stands one cycle
	always @(posedge pclk)
		if (summary_strobe === 1'b1)
			num_sum <= num_sum + 1;

	rca_top #(.TICK_CYC(TK)) i_dut (
		.pclk,
		.presetn,
		.psel,
		.penable,
		.pwrite,
		.paddr,
		.pwdata,
		.prdata,
		.pready,
		.pslverr,
		.trip_asserted,
		.breaker_open,
		.breaker_enable_jumper,
		.alarm_condition,
		.channel_fail,
		.channel_fail_type,
		.event_trigger,
		.group_select_input,
		.alarm_out,
		.close_command_element,
		.remote_control_bit,
		.active_group,
		.group_msg,
		.protection_disable,
		.copy_go,
		.copy_src,
		.copy_dst,
		.summary_strobe
	);

	rca_breaker_model i_brk (
		.pclk,
		.presetn,
		.close_command_element,
		.fast,
		.breaker_open
	);

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// command write followed by a status read
	task automatic cmd(input rca_op_t op, input logic [3:0] a, b, c,
		input logic pw);
		xfer(1'b1, REG_CMD, {15'h0, pw, c, b, a, op});
		xfer(1'b0, REG_STATUS, 32'h0);
	endtask

	task automatic rbit(input logic [3:0] a, b, s, input logic [1:0] k);
		cmd(OP_CONTROL, a, b, 4'h0, 1'b0);
		cmd(OP_SUB, s, 4'h0, {2'h1, k}, 1'b0);
		xfer(1'b0, REG_RBITS, 32'h0);
	endtask

	function automatic logic [31:0] fld(input int lsb, input int w);
		return (rdat >> lsb) & ((32'h1 << w) - 32'h1);
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic close_yes;
		cmd(OP_CLOSE, 4'h0, 4'h0, 4'h0, 1'b0);
		cmd(OP_YES, 4'h0, 4'h0, 4'h0, 1'b0);
		cmd(OP_YES, 4'h0, 4'h0, 4'h0, 1'b0);
		cyc(3);
	endtask

	initial
	begin
		cyc(16);
		presetn <= 1'b1;
		cyc(4);
		xfer(1'b0, REG_STATUS, 32'h0);
		chk(fld(0, 2), 32'(LVL0));
		chk(fld(16, 6), 32'h9);
		cmd(OP_CONTROL, 4'h5, 4'h0, 4'h0, 1'b1);
		chk(32'(fld(4, 4) inside {32'h1, 32'h2}), 32'h1);
		xfer(1'b0, 8'h40, 32'h0);
		chk(32'(rerr), 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			cmd(OP_ACCESS, 4'h0, 4'h0, 4'h0, 1'b0);
			cyc(3);
			chk(32'(alarm_out), 32'(i == 2));
		end
		cyc(AL + 20);
		chk(32'(alarm_out), 32'h0);
		cmd(OP_ACCESS, 4'h0, 4'h0, 4'h0, 1'b1);
		chk(fld(0, 2), 32'(LVL1));
		cmd(OP_GROUP, 4'h3, 4'h0, 4'h0, 1'b0);
		cmd(OP_YES, 4'h0, 4'h0, 4'h0, 1'b0);
		chk(fld(16, 6), 32'h9);
		cmd(OP_BREAKER, 4'h0, 4'h0, 4'h0, 1'b1);
		cyc(3);
		chk(fld(0, 2), 32'(LVL_BRK));
		chk(32'(alarm_out), 32'h1);
		cmd(OP_CLOSE, 4'h0, 4'h0, 4'h0, 1'b0);
		chk(fld(4, 4), 32'(RES_NO_JUMPER));
		breaker_enable_jumper <= 1'b1;
		cyc(3);
		cmd(OP_CLOSE, 4'h0, 4'h0, 4'h0, 1'b0);
		chk(fld(4, 4), 32'(RES_ASK));
		cmd(OP_NO, 4'h0, 4'h0, 4'h0, 1'b0);
		chk(fld(4, 4), 32'(RES_ABORTED));
		cmd(OP_CLOSE, 4'h0, 4'h0, 4'h0, 1'b0);
		cmd(OP_YES, 4'h0, 4'h0, 4'h0, 1'b0);
		cmd(OP_NO, 4'h0, 4'h0, 4'h0, 1'b0);
		chk(fld(4, 4), 32'(RES_ABORTED));
		trip_asserted <= 1'b1;
		cyc(3);
		close_yes();
		chk(32'(close_command_element), 32'h0);
		trip_asserted <= 1'b0;
		cyc(3);
		close_yes();
		chk(32'(close_command_element), 32'h1);
		n = 0;
		while (close_command_element === 1'b1 && n < CC + 100)
		begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n > CC - TK - 10 && n < CC + 4), 32'h1);
		cyc(AL);
		fast <= 1'b1;
		close_yes();
		cyc(30);
		chk(32'(close_command_element), 32'h0);
		alarm_condition <= 1'b1;
		cyc(6);
		cmd(OP_TOP, 4'h0, 4'h0, 4'h0, 1'b1);
		chk(fld(0, 2), 32'(LVL2));
		alarm_condition <= 1'b0;
		cyc(8);
		chk(32'(alarm_out), 32'h0);
		cmd(OP_TOP, 4'h0, 4'h0, 4'h0, 1'b0);
		cyc(3);
		chk(32'(alarm_out), 32'h1);
		rbit(4'h5, 4'h0, 4'h4, SUB_SET);
		chk(rdat, 32'h10);
		rbit(4'h5, 4'h0, 4'h5, SUB_SET);
		chk(rdat, 32'h10);
		rbit(4'h0, 4'h1, 4'hf, SUB_SET);
		chk(rdat, 32'h8010);
		rbit(4'h5, 4'h0, 4'h4, SUB_CLR);
		chk(rdat, 32'h8000);
		rbit(4'h1, 4'h0, 4'h0, SUB_PULSE);
		n = 0;
		while (remote_control_bit[0] === 1'b1 && n < AL + 100)
		begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n > RB_PULSE_DEF_S * AL - TK - 20 && n < AL + 4), 32'h1);
		cmd(OP_EVENT, 4'h0, 4'h0, 4'h0, 1'b0);
		chk(fld(4, 4), 32'(RES_BAD_EVENT));
		event_trigger <= 1'b1;
		cyc(5);
		event_trigger <= 1'b0;
		cyc(5);
		chk(32'(num_sum), 32'h1);
		for (int k = 0; k < 5; k++)
		begin
			cmd(OP_EVENT, 4'(k > 0), 4'(k), 4'h0, 1'b0);
			xfer(1'b0, REG_EVENT, 32'h0);
			chk(fld(0, 8), 32'h1 + 32'(k) * 32'h20);
		end
		cmd(OP_EVENT, 4'hc, 4'h0, 4'h0, 1'b0);
		chk(fld(4, 4), 32'(RES_BAD_EVENT));
		cmd(OP_COPY, 4'h2, 4'h1, 4'h0, 1'b0);
		cmd(OP_YES, 4'h0, 4'h0, 4'h0, 1'b0);
		cyc(3);
		chk(32'({copy_src, copy_dst}), 32'h11);
		chk(32'(alarm_out), 32'h1);
		cmd(OP_EVENT, 4'h1, 4'h0, 4'h0, 1'b0);
		xfer(1'b0, REG_EVENT, 32'h0);
		chk(fld(4, 1), 32'h1);
		cyc(AL + 20);
		cmd(OP_SETCHG, 4'h3, 4'h0, 4'h0, 1'b0);
		chk(fld(4, 4), 32'(RES_OK));
		cyc(3);
		chk(32'(alarm_out), 32'h0);
		cmd(OP_GROUP, 4'h2, 4'h0, 4'h0, 1'b0);
		cmd(OP_YES, 4'h0, 4'h0, 4'h0, 1'b0);
		cyc(3);
		chk(32'(active_group), 32'h2);
		chk(32'(alarm_out), 32'h1);
		alarm_condition <= 1'b1;
		xfer(1'b1, REG_CFG, 32'h7);
		group_select_input <= 3'h4;
		cyc(6);
		chk(32'(active_group), 32'h4);
		group_select_input <= 3'h0;
		cyc(6);
		chk(32'(active_group), 32'h2);
		channel_fail_type <= 3'h5;
		channel_fail <= 1'b1;
		cyc(20);
		channel_fail <= 1'b0;
		cyc(6);
		xfer(1'b1, REG_LOG_IDX, 32'h1);
		xfer(1'b0, REG_LOG_IDX, 32'h0);
		chk(fld(8, 8), 32'h1);
		xfer(1'b0, REG_LOG_INFO, 32'h0);
		chk(fld(16, 3) | fld(31, 1) << 3, 32'hd);
		cmd(OP_LOGCLR, 4'h0, 4'h0, 4'h0, 1'b0);
		xfer(1'b0, REG_LOG_IDX, 32'h0);
		chk(fld(8, 8), 32'h0);
		test_done();
	end

	initial
	begin
		cyc(95000);
		num_errors++;
		test_done();
	end
endmodule
`default_nettype wire
